// File: inc/act_pkg.sv
// shared constants for the converter timing and clock control block
// assumes a single system-rate input clock; all slower rates are enables
package act_pkg;

   localparam int unsigned CLK_MHZ       = 250;
   localparam int unsigned CLK_PERIOD_NS = 4;

   // basic clock selector codes and divide factors
   localparam logic [1:0] BC_SEL_DIV4  = 2'h0;
   localparam logic [1:0] BC_SEL_DIV2  = 2'h1;
   localparam logic [1:0] BC_SEL_DIV16 = 2'h2;
   localparam logic [1:0] BC_SEL_DIV8  = 2'h3;
   localparam logic [4:0] BC_DIV4      = 5'h04;
   localparam logic [4:0] BC_DIV2      = 5'h02;
   localparam logic [4:0] BC_DIV16     = 5'h10;
   localparam logic [4:0] BC_DIV8      = 5'h08;

   // sample time selector codes and lengths in basic clock periods
   localparam logic [1:0] ST_SEL_8     = 2'h0;
   localparam logic [1:0] ST_SEL_16    = 2'h1;
   localparam logic [1:0] ST_SEL_32    = 2'h2;
   localparam logic [1:0] ST_SEL_64    = 2'h3;
   localparam logic [7:0] ST_LEN_8     = 8'h08;
   localparam logic [7:0] ST_LEN_16    = 8'h10;
   localparam logic [7:0] ST_LEN_32    = 8'h20;
   localparam logic [7:0] ST_LEN_64    = 8'h40;

   // conversion phase lengths in basic clock periods
   localparam logic [7:0] CONV_10_CAL  = 8'h34;
   localparam logic [7:0] CONV_8_CAL   = 8'h2C;
   localparam logic [7:0] POSTCAL_LEN  = 8'h0C;
   // result register load phase, in system clock periods
   localparam logic [7:0] LOAD_SYS_LEN = 8'h06;

   // reset calibration bounds in basic clock periods
   localparam int unsigned CAL_MIN_BC  = 484;
   localparam int unsigned CAL_MAX_BC  = 11696;

   // saturated result codes
   localparam logic [9:0] RES_ZERO     = 10'h000;
   localparam logic [9:0] RES_FULL     = 10'h3FF;

   // master clock source selection
   localparam logic [1:0] MC_SRC_DIRECT = 2'h0;
   localparam logic [1:0] MC_SRC_BYPASS = 2'h1;
   localparam logic [1:0] MC_SRC_LOOP   = 2'h3;

   typedef enum logic [1:0] {
      ACT_IDLE,
      ACT_SAMPLE,
      ACT_CONVERT,
      ACT_LOAD
   } act_state_e;

endpackage

// File: src/act_tick_div.sv
// enable divider: one tick for every div_in input enables
// assumes div_in stays stable while counting; a change acts on the running count at once
`timescale 1ns/1ns
`default_nettype none
module act_tick_div #(
   parameter int unsigned W = 7
) (
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic         en_in,
   input  wire logic [W-1:0] div_in,
   output logic              tick
);

   logic [W-1:0] cnt_reg;
   logic         hit;

   assign hit  = (cnt_reg >= div_in - W'(1));
   assign tick = en_in && hit;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else if (en_in) begin
         cnt_reg <= hit ? '0 : cnt_reg + W'(1);
      end
   end

endmodule
`default_nettype wire

// File: src/act_top.sv
// converter timing, calibration and clock enable control
// assumes start/config from same-clock logic; analog status from pins
//
// Contract
// R1: the basic clock is the system clock divided by 4, 2, 16 or 8 for codes 00..11.
// R2: the sample phase lasts 8, 16, 32 or 64 basic clock periods for codes 00..11.
// R3: a 10-bit conversion with post-calibration takes 52 basic periods plus sample plus 6 system periods.
// R4: an 8-bit conversion with post-calibration takes 44 basic periods plus sample plus 6 system periods.
// R5: without post-calibration every conversion is 12 basic periods shorter.
// R6: input below reference ground gives all-zero bits, above reference supply all ten bits set.
// R7: after reset a calibration runs for 484 to 11696 basic periods, longer while the reference is noisy.
// R8: conversions may start during reset calibration and lengthen it.
// R9: software keeps the basic clock between 0.5 and 20 MHz.
// R10: the cpu clock is the master clock or half of it, chosen by one bit.
// R11: the system clock for the peripherals runs at the cpu clock rate.
// R12: the master clock configuration selects how the master clock is made from the oscillator.
// R13: in bypass the master clock is the oscillator divided by (input divider+1)*(output divider+1).
// R14: at the end of a conversion the result is loaded and a complete flag is raised.
`timescale 1ns/1ns
`default_nettype none
module act_top
   import act_pkg::*;
#(
   parameter int unsigned CAL_MIN = CAL_MIN_BC,
   parameter int unsigned CAL_MAX = CAL_MAX_BC
) (
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic [1:0] master_clock_config_reg,
   input  wire logic [1:0] input_divider_factor,
   input  wire logic [3:0] output_divider_factor,
   input  wire logic       cpu_clock_halver,
   input  wire logic [1:0] basic_clock_select,
   input  wire logic [1:0] sample_time_select,
   input  wire logic       res_8bit,
   input  wire logic       postcal_en,
   input  wire logic       conv_start,
   input  wire logic       ain_below,
   input  wire logic       ain_above,
   input  wire logic [9:0] ain_code,
   input  wire logic       ref_noisy,
   output logic            master_tick,
   output logic            cpu_tick,
   output logic            sys_tick,
   output logic            bc_tick,
   output logic            sample_hold,
   output logic            conv_busy,
   output logic            cal_active,
   output logic [9:0]      result_reg,
   output logic            conv_done
);

   // ************************************************************
   // input synchronisers
   // ************************************************************
   logic [12:0] pin_s1_reg;
   logic [12:0] pin_s2_reg;
   logic        below_s;
   logic        above_s;
   logic        noisy_s;
   logic [9:0]  code_s;

   // code is read only at the end of the load phase, long after it settled
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
      end else begin
         pin_s1_reg <= {ain_below, ain_above, ref_noisy, ain_code};
         pin_s2_reg <= pin_s1_reg;
      end
   end
   assign {below_s, above_s, noisy_s, code_s} = pin_s2_reg;

   // ************************************************************
   // master, cpu and system clock enables
   // ************************************************************
   logic [6:0] byp_div;
   logic       byp_tick;
   logic       half_reg;

   assign byp_div = 7'((input_divider_factor + 3'h1) * (output_divider_factor + 5'h01)); // R13

   act_tick_div #(.W(7)) u_byp_div (
      .clock  (clock),
      .nrst   (nrst),
      .en_in  (1'b1),
      .div_in (byp_div),
      .tick   (byp_tick)
   );

   // loop source has no model here; it runs at oscillator rate
   always_comb begin
      case (master_clock_config_reg) // R12
         MC_SRC_BYPASS: master_tick = byp_tick; // R13
         default:       master_tick = 1'b1;
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         half_reg <= 1'b0;
      end else if (master_tick) begin
         half_reg <= ~half_reg;
      end
   end

   assign cpu_tick = master_tick && (!cpu_clock_halver || half_reg); // R10
   assign sys_tick = cpu_tick; // R11

   // ************************************************************
   // converter basic clock
   // ************************************************************
   logic [4:0] bc_div;

   always_comb begin
      case (basic_clock_select) // R1
         BC_SEL_DIV4:  bc_div = BC_DIV4;
         BC_SEL_DIV2:  bc_div = BC_DIV2;
         BC_SEL_DIV16: bc_div = BC_DIV16;
         BC_SEL_DIV8:  bc_div = BC_DIV8;
         default:      bc_div = BC_DIV4;
      endcase
   end

   // range of the resulting rate is software's concern, not checked here
   act_tick_div #(.W(5)) u_bc_div ( // R9
      .clock  (clock),
      .nrst   (nrst),
      .en_in  (sys_tick),
      .div_in (bc_div),
      .tick   (bc_tick)
   );

   // ************************************************************
   // conversion sequencer
   // ************************************************************
   act_state_e state_reg;
   logic [7:0] ph_cnt_reg;
   logic [7:0] st_len;
   logic [7:0] conv_len;
   logic       mode8_reg;
   logic       pcal_reg;

   always_comb begin
      case (sample_time_select) // R2
         ST_SEL_8:  st_len = ST_LEN_8;
         ST_SEL_16: st_len = ST_LEN_16;
         ST_SEL_32: st_len = ST_LEN_32;
         ST_SEL_64: st_len = ST_LEN_64;
         default:   st_len = ST_LEN_8;
      endcase
   end

   // mode is latched at start so a mid-conversion change cannot skew length
   always_comb begin
      conv_len = mode8_reg ? CONV_8_CAL : CONV_10_CAL; // R3 R4
      if (!pcal_reg) begin
         conv_len = conv_len - POSTCAL_LEN; // R5
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg  <= ACT_IDLE;
         ph_cnt_reg <= '0;
         mode8_reg  <= 1'b0;
         pcal_reg   <= 1'b1;
      end else begin
         case (state_reg)
            ACT_IDLE: begin
               // starts are honoured during calibration too
               if (conv_start) begin // R8
                  state_reg  <= ACT_SAMPLE;
                  ph_cnt_reg <= '0;
                  mode8_reg  <= res_8bit;
                  pcal_reg   <= postcal_en;
               end
            end
            ACT_SAMPLE: begin
               if (bc_tick) begin
                  if (ph_cnt_reg == st_len - 8'h01) begin // R2
                     state_reg  <= ACT_CONVERT;
                     ph_cnt_reg <= '0;
                  end else begin
                     ph_cnt_reg <= ph_cnt_reg + 8'h01;
                  end
               end
            end
            ACT_CONVERT: begin
               if (bc_tick) begin
                  if (ph_cnt_reg == conv_len - 8'h01) begin // R3 R4 R5
                     state_reg  <= ACT_LOAD;
                     ph_cnt_reg <= '0;
                  end else begin
                     ph_cnt_reg <= ph_cnt_reg + 8'h01;
                  end
               end
            end
            ACT_LOAD: begin
               if (sys_tick) begin
                  if (ph_cnt_reg == LOAD_SYS_LEN - 8'h01) begin // R3 R4
                     state_reg  <= ACT_IDLE;
                     ph_cnt_reg <= '0;
                  end else begin
                     ph_cnt_reg <= ph_cnt_reg + 8'h01;
                  end
               end
            end
            default: begin
               state_reg  <= ACT_IDLE;
               ph_cnt_reg <= '0;
            end
         endcase
      end
   end

   logic load_end;
   assign load_end = (state_reg == ACT_LOAD) && sys_tick
                     && (ph_cnt_reg == LOAD_SYS_LEN - 8'h01);

   assign sample_hold = (state_reg == ACT_SAMPLE);
   assign conv_busy   = (state_reg != ACT_IDLE);

   // ************************************************************
   // result register and complete flag
   // ************************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         result_reg <= RES_ZERO;
         conv_done  <= 1'b0;
      end else begin
         conv_done <= load_end; // R14
         if (load_end) begin
            if (below_s) begin
               result_reg <= RES_ZERO; // R6
            end else if (above_s) begin
               result_reg <= RES_FULL; // R6
            end else begin
               result_reg <= code_s; // R14
            end
         end
      end
   end

   // ************************************************************
   // reset calibration
   // ************************************************************
   logic [13:0] cal_cnt_reg;
   logic        cal_min_ok;
   logic        cal_stop;

   assign cal_min_ok = (cal_cnt_reg >= 14'(CAL_MIN - 1));
   assign cal_stop   = bc_tick && !conv_busy
                       && ((cal_min_ok && !noisy_s) || cal_cnt_reg >= 14'(CAL_MAX - 1));

   // a conversion freezes the count, which stretches the sequence
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cal_active  <= 1'b1;
         cal_cnt_reg <= '0;
      end else if (cal_active && bc_tick && !conv_busy) begin // R7 R8
         if (cal_stop) begin
            cal_active <= 1'b0;
         end else begin
            cal_cnt_reg <= cal_cnt_reg + 14'h0001;
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   logic [4:0] sys_gap_reg;
   logic [1:0] bsel_seen_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sys_gap_reg   <= '0;
         bsel_seen_reg <= BC_SEL_DIV4;
      end else begin
         bsel_seen_reg <= basic_clock_select;
         if (bc_tick) begin
            sys_gap_reg <= '0;
         end else if (basic_clock_select != bsel_seen_reg) begin
            sys_gap_reg <= 5'h10; // selector moved mid-interval; bit 4 voids this gap
         end else if (sys_tick) begin
            sys_gap_reg <= sys_gap_reg + 5'h01;
         end
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   a_bc_ratio: assert property ( // R1
      bc_tick && $stable(basic_clock_select) && $past(bc_tick) == 1'b0 && !sys_gap_reg[4]
      && sys_gap_reg != 5'h00 |-> sys_gap_reg == bc_div - 5'h01)
      else $error("basic clock ratio wrong");
   a_bc_on_sys: assert property (bc_tick |-> sys_tick) // R1
      else $error("basic tick outside system tick");
   a_sample_len: assert property ( // R2
      state_reg == ACT_SAMPLE ##1 state_reg == ACT_CONVERT
      |-> $past(ph_cnt_reg) == st_len - 8'h01)
      else $error("sample length wrong");
   a_conv10_len: assert property ( // R3
      state_reg == ACT_CONVERT && !mode8_reg && pcal_reg ##1 state_reg == ACT_LOAD
      |-> $past(ph_cnt_reg) == CONV_10_CAL - 8'h01)
      else $error("10-bit length wrong");
   a_conv8_len: assert property ( // R4
      state_reg == ACT_CONVERT && mode8_reg && pcal_reg ##1 state_reg == ACT_LOAD
      |-> $past(ph_cnt_reg) == CONV_8_CAL - 8'h01)
      else $error("8-bit length wrong");
   a_nopcal_len: assert property ( // R5
      state_reg == ACT_CONVERT && !pcal_reg ##1 state_reg == ACT_LOAD
      |-> $past(ph_cnt_reg) + POSTCAL_LEN == (mode8_reg ? CONV_8_CAL : CONV_10_CAL) - 8'h01)
      else $error("short conversion length wrong");
   a_sat_low: assert property (load_end && below_s |=> conv_done && result_reg == RES_ZERO) // R6
      else $error("low saturation wrong");
   a_sat_high: assert property ( // R6
      load_end && !below_s && above_s |=> result_reg == RES_FULL)
      else $error("high saturation wrong");
   a_cal_bounds: assert property ( // R7
      $fell(cal_active) |-> $past(cal_cnt_reg) >= 14'(CAL_MIN - 1)
      && $past(cal_cnt_reg) <= 14'(CAL_MAX - 1))
      else $error("calibration length out of bounds");
   a_cal_hold: assert property (cal_active && conv_busy |=> $stable(cal_cnt_reg)) // R8
      else $error("calibration advanced during conversion");
   a_cpu_half: assert property ( // R10
      cpu_clock_halver && cpu_tick |-> half_reg ##1 (!cpu_clock_halver || !cpu_tick))
      else $error("cpu clock not halved");
   a_bypass_div: assert property ( // R13
      master_clock_config_reg == MC_SRC_BYPASS && master_tick |-> byp_tick)
      else $error("bypass master clock wrong");
   a_done_pulse: assert property (conv_done |=> !conv_done) // R14
      else $error("complete flag longer than one cycle");
   c_conv10: cover property (state_reg == ACT_LOAD && !mode8_reg ##1 conv_done);
   c_conv8_nopcal: cover property (state_reg == ACT_LOAD && mode8_reg && !pcal_reg ##1 conv_done);
   c_cal_end: cover property ($fell(cal_active));
   c_conv_in_cal: cover property (cal_active && conv_done);
endmodule
`default_nettype wire

// File: tb/act_analog_model.sv
// analog array stand-in: range flags, held code, reference noise
// assumes the bench picks level, code and noise before each start
`timescale 1ns/1ns
`default_nettype none
module act_analog_model
   import act_pkg::*;
(
   input  wire logic       conv_busy,
   input  wire logic [1:0] lvl,
   input  wire logic [9:0] code,
   input  wire logic       noisy,
   output logic            ain_below,
   output logic            ain_above,
   output logic [9:0]      ain_code,
   output logic            ref_noisy
);
   // outside a conversion the array shows the inverse, so a stale read fails
   always_comb begin
      ain_below = lvl[0];
      ain_above = lvl[1];
      ref_noisy = noisy;
      ain_code  = conv_busy ? code : ~code;
   end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the converter timing and clock enable block
// assumes the analog model on the pins; inputs change at falling edges
`timescale 1ns/1ns
`default_nettype none
module testbench
   import act_pkg::*;
;
   // small calibration bounds keep the run short
   localparam int unsigned CMIN = 4;
   localparam int unsigned CMAX = 20;
   logic       clock = 1'b0;
   logic       nrst, halver, r8, pcal, start, noisy;
   logic [1:0] mcfg, idiv, bsel, ssel, lvl;
   logic [3:0] odiv;
   logic [9:0] code, acode, result;
   logic       below, above, rnoisy;
   logic       mtick, ctick, stick, btick, shold, busy, cal, done;
   int         error_cnt = 0;
   int         comparisons = 0;
   int         bc_div [4] = '{4, 2, 16, 8};
   int         st_len [4] = '{8, 16, 32, 64};
   int         cv_len [4] = '{40, 52, 32, 44};

   always #2 clock = ~clock;

   act_top #(.CAL_MIN(CMIN), .CAL_MAX(CMAX)) u_act_top (
      .clock(clock), .nrst(nrst), .master_clock_config_reg(mcfg),
      .input_divider_factor(idiv), .output_divider_factor(odiv),
      .cpu_clock_halver(halver), .basic_clock_select(bsel),
      .sample_time_select(ssel), .res_8bit(r8), .postcal_en(pcal),
      .conv_start(start), .ain_below(below), .ain_above(above),
      .ain_code(acode), .ref_noisy(rnoisy), .master_tick(mtick),
      .cpu_tick(ctick), .sys_tick(stick), .bc_tick(btick),
      .sample_hold(shold), .conv_busy(busy), .cal_active(cal),
      .result_reg(result), .conv_done(done));

   act_analog_model u_act_analog_model (
      .conv_busy(busy), .lvl(lvl), .code(code), .noisy(noisy),
      .ain_below(below), .ain_above(above), .ain_code(acode), .ref_noisy(rnoisy));

   // ****************************************
   // compare and sequence tasks
   // ****************************************
   task automatic cmp_eq(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask

   task automatic cmp_rng(input logic [31:0] got, input int lo, input int hi, input string msg);
      comparisons++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         error_cnt++;
         $display("MISMATCH %0t %s got %0d range %0d..%0d", $time, msg, got, lo, hi);
      end
   endtask

   task automatic end_of_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic do_reset(input logic nz);
      @(negedge clock);
      noisy = nz;
      nrst = 1'b0;
      repeat (6) @(negedge clock);
      nrst = 1'b1;
   endtask

   task automatic cal_wait(input int lo, input int hi);
      int b;
      int t;
      b = 0;
      t = 0;
      while (cal === 1'b1 && t < 20000) begin
         b += (btick === 1'b1);
         t++;
         @(negedge clock);
      end
      cmp_rng(b, lo, hi, "calibration ticks");
   endtask

   // start lands one cycle after a basic tick, so the first period is known
   task automatic convert(input int m, input int s, input logic [1:0] lv, input logic [9:0] c);
      int n;
      int cnt;
      int hold;
      n = 16 * (cv_len[m] + st_len[s]);
      r8 = m[1];
      pcal = m[0];
      ssel = s[1:0];
      lvl = lv;
      code = c;
      cnt = 0;
      repeat (3) @(negedge clock);
      while (btick !== 1'b1 && cnt < 64) begin
         @(negedge clock);
         cnt++;
      end
      @(negedge clock);
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      cnt = 1;
      hold = (shold === 1'b1);
      while (done !== 1'b1 && cnt < 4000) begin
         @(negedge clock);
         hold += (shold === 1'b1);
         cnt++;
         // a second request in mid-conversion must be ignored
         start = (cnt == 20);
      end
      cmp_rng(cnt, n + 6, n + 7, "conversion time");
      cmp_rng(hold, st_len[s] * 16 - 2, st_len[s] * 16, "sample time");
      cmp_eq(result, lv[0] ? RES_ZERO : (lv[1] ? RES_FULL : c), "result");
      cmp_eq(busy, 1'b0, "busy at done");
      @(negedge clock);
      cmp_eq(done, 1'b0, "done width");
      repeat (2) @(negedge clock);
      cmp_eq(busy, 1'b0, "refused start");
   endtask

   task automatic tick_test(input logic [1:0] mc, input logic [1:0] id, input logic [3:0] od,
                            input logic hv, input int bs);
      int f;
      int m;
      int s;
      int b;
      int d;
      mcfg = mc;
      idiv = id;
      odiv = od;
      halver = hv;
      bsel = bs[1:0];
      f = (mc == 2'h1) ? (id + 1) * (od + 1) : 1;
      m = 0;
      s = 0;
      b = 0;
      d = 0;
      // ratio changes act on the running count at once, so let the slowest divider turn over
      repeat (500) @(negedge clock);
      repeat (1920) begin
         @(negedge clock);
         m += (mtick === 1'b1);
         s += (stick === 1'b1);
         b += (btick === 1'b1);
         d += (ctick !== stick);
      end
      cmp_eq(m, 1920 / f, "master ticks");
      cmp_eq(s, 1920 / f / (hv + 1), "system ticks");
      cmp_eq(b, 1920 / f / (hv + 1) / bc_div[bs], "basic ticks");
      cmp_eq(d, 0, "cpu and system ticks");
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      nrst = 1'b0;
      mcfg = 2'h0;
      idiv = 2'h2;
      odiv = 4'h3;
      halver = 1'b0;
      bsel = 2'h2;
      ssel = 2'h0;
      r8 = 1'b0;
      pcal = 1'b0;
      start = 1'b0;
      lvl = 2'h0;
      code = 10'h2A5;
      noisy = 1'b0;
      do_reset(1'b0);
      cmp_eq(result, RES_ZERO, "result at reset");
      cmp_eq({busy, done, shold}, 3'h0, "idle at reset");
      cmp_eq(cal, 1'b1, "calibration at reset");
      cal_wait(CMIN - 1, CMIN + 1);
      do_reset(1'b1);
      cal_wait(CMAX - 1, CMAX + 1);
      do_reset(1'b1);
      convert(2, 0, 2'h0, 10'h155);
      cmp_eq(cal, 1'b1, "calibration held");
      cal_wait(CMAX - 4, CMAX + 1);
      // basic clock stays at sys/16, inside the legal band
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 4; s++) begin
            convert(m, s, 2'h0, 10'h2A5 ^ 10'(s));
         end
      end
      for (int l = 1; l < 4; l++) begin
         convert(3, 0, l[1:0], 10'h15A);
      end
      for (int i = 0; i < 4; i++) begin
         tick_test(i[1:0], 2'h2, 4'h3, 1'b0, 2);
      end
      for (int i = 0; i < 4; i++) begin
         tick_test(2'h1, 2'h2, 4'h3, 1'b0, i);
      end
      tick_test(2'h1, 2'h2, 4'h3, 1'b1, 2);
      tick_test(2'h1, 2'h0, 4'hE, 1'b0, 2);
      end_of_test();
   end

   initial begin
      // tests take about 50000 cycles; the margin stays well under the run limit
      #(80000 * CLK_PERIOD_NS);
      error_cnt++;
      $display("MISMATCH %0t watchdog expired", $time);
      end_of_test();
   end
endmodule
`default_nettype wire
